// ==== core/pwst_pkg.sv ====
// Purpose: Shared constants and types for the secondary time base block.
// Assumes: 16-bit registers on a plain address/strobe port.
// Notes:   Field positions are carried by the packed register structs.
package pwst_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] ADDR_SEC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLKDIV = 4'h1;
    localparam logic [3:0] ADDR_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_COMPARE = 4'h3;
    localparam logic [3:0] ADDR_CHOP = 4'h4;
    localparam logic [3:0] ADDR_SHARED_DUTY = 4'h5;
    localparam logic [3:0] ADDR_GEN_CTRL = 4'h6;

    // ==========================================================
    // Reset values and the reserved divider code
    localparam logic [15:0] PERIOD_RST = 16'hfff8;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    localparam logic [2:0] CLKDIV_RST = 3'h0;
    localparam logic [2:0] CLKDIV_RESERVED = 3'h7;

    // ==========================================================
    // Register layouts
    typedef struct packed {
        logic [2:0] unused_hi;
        logic special_event_pending;
        logic special_event_irq_enable;
        logic immediate_period_update;
        logic [5:0] unused_lo;
        logic [3:0] event_postscale_select;
    } pwst_sec_ctrl_type;

    typedef struct packed {
        logic chop_gen_enable;
        logic [4:0] unused;
        logic [9:0] chop_divider;
    } pwst_chop_type;

    typedef struct packed {
        logic fault_pending;
        logic climit_pending;
        logic trigger_pending;
        logic fault_irq_enable;
        logic climit_irq_enable;
        logic trigger_irq_enable;
        logic own_timebase_mode;
        logic shared_duty_select;
        logic [1:0] deadtime_mode;
        logic comp_polarity;
        logic unused;
        logic timebase_select;
        logic center_align_enable;
        logic ext_period_reset;
        logic immediate_update;
    } pwst_gen_ctrl_type;

    typedef struct packed {
        logic [15:0] duty;
        logic [15:0] period;
        logic [13:0] deadtime;
        logic [13:0] alt_deadtime;
    } pwst_active_type;

    // Dead-time mode codes.
    localparam logic [1:0] DT_COMPENSATE = 2'h3;
endpackage

// ==== core/pwst_top.sv ====
// Purpose: Secondary master time base, chop clock, shared duty and one
//          generator control register of a multi-generator PWM unit.
// Assumes: One 10 MHz clock; all inputs synchronous to it.
// Notes:   Read data stand in the cycle after the read strobe only.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Special event trigger emitted once per postscale-plus-one compare matches.
// - Divider codes 000..110 divide by 1..64; 111 reserved; 000 default.
// - Secondary period register 16 bits, resets to 16'hfff8.
// - Secondary event compare register 16 bits, resets to zero.
// - Chop generator runs only while its enable bit 15 is set.
// - Chop rate is clock over divider over chop divider plus one.
// - Duty comes from shared duty when select set, else generator duty.
// - Fault status set on event while enabled; clearing enable clears status.
// - Current-limit status set on event while enabled; enable clear clears.
// - Trigger event sets status and requests interrupt while enabled.
// - Own time base mode takes period from phase, else secondary or primary period per time base select.
// - Dead-time field: positive, negative, disabled, compensation.
// - Compensation polarity and input choose which output is shortened.
// - Polarity bit ignored unless dead-time field is compensation.
// - Time base select picks secondary or primary master time base.
// - Center alignment only honoured in own time base mode.
// - Ext reset: current-limit resets time base in own mode, limit off.
// - Immediate update loads active values at once, else at period end.
// - Immediate period update loads secondary period at once, else at wrap.
// - Special event pending set by hardware, cleared by hardware.
module pwst_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic MODULE_ENABLE,
    input wire logic CLIMIT_MODE,
    input wire logic FAULT_EVT,
    input wire logic CLIMIT_EVT,
    input wire logic TRIGGER_EVT,
    input wire logic PRI_PERIOD_END,
    input wire logic [15:0] PRIMARY_PERIOD,
    input wire logic [15:0] GEN_DUTY,
    input wire logic [15:0] GEN_PHASE,
    input wire logic [13:0] DT_VALUE,
    input wire logic [13:0] ALT_DT_VALUE,
    input wire logic COMP_INPUT,
    output logic SPECIAL_EVENT_TRIG,
    output logic SEC_MATCH,
    output logic SE_IRQ,
    output logic GEN_IRQ,
    output logic CHOP_CLK,
    output logic TB_RESET,
    output pwst_pkg::pwst_active_type ACTIVE,
    output logic [1:0] DT_MODE,
    output logic SHORTEN_HIGH,
    output logic SHORTEN_LOW,
    output logic CENTER_ALIGN,
    output logic USE_SEC_TB
);
    // ==========================================================
    // Register file
    pwst_pkg::pwst_sec_ctrl_type sec_ctrl_r;
    logic [2:0] clkdiv_r;
    logic [15:0] period_r;
    logic [15:0] compare_r;
    pwst_pkg::pwst_chop_type chop_r;
    logic [15:0] shared_duty_r;
    pwst_pkg::pwst_gen_ctrl_type gen_ctrl_r;
    logic [15:0] rdata_nxt;

    logic wr_sec;
    logic wr_gen;
    assign wr_sec = WR && (ADDR == pwst_pkg::ADDR_SEC_CTRL);
    assign wr_gen = WR && (ADDR == pwst_pkg::ADDR_GEN_CTRL);

    // Status bits are hardware owned; software writes leave them alone.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sec_ctrl_r.unused_hi <= 3'h0;
            sec_ctrl_r.special_event_pending <= 1'b0;
            sec_ctrl_r.special_event_irq_enable <= 1'b0;
            sec_ctrl_r.immediate_period_update <= 1'b0;
            sec_ctrl_r.unused_lo <= 6'h00;
            sec_ctrl_r.event_postscale_select <= 4'h0;
        end else if (wr_sec) begin
            sec_ctrl_r.special_event_irq_enable <= WDATA[11];
            sec_ctrl_r.immediate_period_update <= WDATA[10];
            sec_ctrl_r.event_postscale_select <= WDATA[3:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            clkdiv_r <= pwst_pkg::CLKDIV_RST;
            period_r <= pwst_pkg::PERIOD_RST;
            compare_r <= pwst_pkg::ZERO_RST;
            chop_r <= pwst_pkg::ZERO_RST;
            shared_duty_r <= pwst_pkg::ZERO_RST;
        end else if (WR) begin
            if (ADDR == pwst_pkg::ADDR_CLKDIV) begin
                clkdiv_r <= WDATA[2:0];
            end else if (ADDR == pwst_pkg::ADDR_PERIOD) begin
                period_r <= WDATA;
            end else if (ADDR == pwst_pkg::ADDR_COMPARE) begin
                compare_r <= WDATA;
            end else if (ADDR == pwst_pkg::ADDR_CHOP) begin
                chop_r.chop_gen_enable <= WDATA[15];
                chop_r.chop_divider <= WDATA[9:0];
            end else if (ADDR == pwst_pkg::ADDR_SHARED_DUTY) begin
                shared_duty_r <= WDATA;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            gen_ctrl_r <= 16'h0000;
        end else if (wr_gen) begin
            gen_ctrl_r[12:5] <= WDATA[12:5];
            gen_ctrl_r.unused <= 1'b0;
            gen_ctrl_r[3:0] <= WDATA[3:0];
        end
    end

    // ==========================================================
    // Pending status bits of the generator
    logic [2:0] gen_evt;
    logic [2:0] gen_ien;
    logic [2:0] gen_stat_r;
    assign gen_evt = {FAULT_EVT, CLIMIT_EVT, TRIGGER_EVT};
    assign gen_ien = gen_ctrl_r[12:10];

    // An event in the cycle the enable drops still lands; the low
    // enable then clears it on the next edge.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_stat
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    gen_stat_r[gi] <= 1'b0;
                end else if (gen_evt[gi] && gen_ien[gi]) begin
                    gen_stat_r[gi] <= 1'b1;
                end else if (!gen_ien[gi]) begin
                    gen_stat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Input clock divider
    logic [5:0] pre_cnt_r;
    logic [5:0] pre_mask;
    logic tick;

    // Reserved code falls back to divide-by-1 rather than stalling.
    always_comb begin
        if (clkdiv_r == pwst_pkg::CLKDIV_RESERVED) begin
            pre_mask = 6'h00;
        end else begin
            pre_mask = 6'((7'h01 << clkdiv_r) - 7'h01);
        end
    end
    assign tick = (pre_cnt_r == pre_mask);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pre_cnt_r <= 6'h00;
        end else if (tick || !(MODULE_ENABLE || chop_r.chop_gen_enable)) begin
            pre_cnt_r <= 6'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
        end
    end

    // ==========================================================
    // Secondary time base
    logic [15:0] sec_cnt_r;
    logic [15:0] sec_per_r;
    logic [3:0] post_cnt_r;
    logic sec_tick;
    logic sec_wrap;
    logic sec_match;
    logic post_hit;
    assign sec_tick = tick && MODULE_ENABLE;
    assign sec_wrap = sec_tick && (sec_cnt_r >= sec_per_r);
    assign sec_match = sec_tick && (sec_cnt_r == compare_r);
    assign post_hit = sec_match &&
        (post_cnt_r == sec_ctrl_r.event_postscale_select);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sec_cnt_r <= 16'h0000;
        end else if (!MODULE_ENABLE || sec_wrap) begin
            sec_cnt_r <= 16'h0000;
        end else if (sec_tick) begin
            sec_cnt_r <= sec_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sec_per_r <= pwst_pkg::PERIOD_RST;
        end else if (sec_ctrl_r.immediate_period_update || sec_wrap ||
                     !MODULE_ENABLE) begin
            sec_per_r <= period_r;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            post_cnt_r <= 4'h0;
        end else if (!MODULE_ENABLE || post_hit) begin
            post_cnt_r <= 4'h0;
        end else if (sec_match) begin
            post_cnt_r <= post_cnt_r + 4'h1;
        end
    end

    // The pending flag has no software clear; it drops with the enable.
    // It is kept apart from the control word so each has one driver.
    logic se_pend_r;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            se_pend_r <= 1'b0;
        end else if (post_hit && sec_ctrl_r.special_event_irq_enable) begin
            se_pend_r <= 1'b1;
        end else if (!sec_ctrl_r.special_event_irq_enable) begin
            se_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Chop clock: one pulse per (divider + 1) divided ticks
    logic [9:0] chop_cnt_r;
    logic chop_end;
    assign chop_end = tick && (chop_cnt_r == chop_r.chop_divider);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            chop_cnt_r <= 10'h000;
        end else if (!chop_r.chop_gen_enable || chop_end) begin
            chop_cnt_r <= 10'h000;
        end else if (tick) begin
            chop_cnt_r <= chop_cnt_r + 10'h001;
        end
    end

    // ==========================================================
    // Active values of the generator
    logic boundary;
    pwst_pkg::pwst_active_type active_nxt;
    assign boundary = gen_ctrl_r.timebase_select ? sec_wrap : PRI_PERIOD_END;

    always_comb begin
        active_nxt.duty = gen_ctrl_r.shared_duty_select ?
            shared_duty_r : GEN_DUTY;
        if (gen_ctrl_r.own_timebase_mode) begin
            active_nxt.period = GEN_PHASE;
        end else if (gen_ctrl_r.timebase_select) begin
            active_nxt.period = sec_per_r;
        end else begin
            active_nxt.period = PRIMARY_PERIOD;
        end
        active_nxt.deadtime = DT_VALUE;
        active_nxt.alt_deadtime = ALT_DT_VALUE;
    end

    // ==========================================================
    // Output flops
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ACTIVE <= '0;
        end else if (gen_ctrl_r.immediate_update || boundary) begin
            ACTIVE <= active_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            SPECIAL_EVENT_TRIG <= 1'b0;
            SEC_MATCH <= 1'b0;
            CHOP_CLK <= 1'b0;
            TB_RESET <= 1'b0;
            SE_IRQ <= 1'b0;
            GEN_IRQ <= 1'b0;
        end else begin
            SPECIAL_EVENT_TRIG <= post_hit;
            SEC_MATCH <= sec_match;
            CHOP_CLK <= chop_end && chop_r.chop_gen_enable;
            TB_RESET <= gen_ctrl_r.ext_period_reset && CLIMIT_EVT &&
                gen_ctrl_r.own_timebase_mode && !CLIMIT_MODE;
            SE_IRQ <= se_pend_r;
            GEN_IRQ <= |gen_stat_r;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            DT_MODE <= 2'h0;
            SHORTEN_HIGH <= 1'b0;
            SHORTEN_LOW <= 1'b0;
            CENTER_ALIGN <= 1'b0;
            USE_SEC_TB <= 1'b0;
        end else begin
            DT_MODE <= gen_ctrl_r.deadtime_mode;
            if (gen_ctrl_r.deadtime_mode == pwst_pkg::DT_COMPENSATE) begin
                SHORTEN_LOW <= gen_ctrl_r.comp_polarity ^ COMP_INPUT;
                SHORTEN_HIGH <= ~(gen_ctrl_r.comp_polarity ^ COMP_INPUT);
            end else begin
                SHORTEN_LOW <= 1'b0;
                SHORTEN_HIGH <= 1'b0;
            end
            CENTER_ALIGN <= gen_ctrl_r.center_align_enable &&
                gen_ctrl_r.own_timebase_mode;
            USE_SEC_TB <= gen_ctrl_r.timebase_select;
        end
    end

    // ==========================================================
    // Read port
    always_comb begin
        rdata_nxt = 16'h0000;
        if (ADDR == pwst_pkg::ADDR_SEC_CTRL) begin
            rdata_nxt = {sec_ctrl_r[15:13], se_pend_r, sec_ctrl_r[11:0]};
        end else if (ADDR == pwst_pkg::ADDR_CLKDIV) begin
            rdata_nxt = {13'h0000, clkdiv_r};
        end else if (ADDR == pwst_pkg::ADDR_PERIOD) begin
            rdata_nxt = period_r;
        end else if (ADDR == pwst_pkg::ADDR_COMPARE) begin
            rdata_nxt = compare_r;
        end else if (ADDR == pwst_pkg::ADDR_CHOP) begin
            rdata_nxt = chop_r;
        end else if (ADDR == pwst_pkg::ADDR_SHARED_DUTY) begin
            rdata_nxt = shared_duty_r;
        end else if (ADDR == pwst_pkg::ADDR_GEN_CTRL) begin
            rdata_nxt = {gen_stat_r, gen_ctrl_r[12:0]};
        end
    end

    // Data are held only for the one cycle after the read strobe.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            RDATA <= rdata_nxt;
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule // pwst_top

`default_nettype wire

// ==== verification/pwst_top_chk.sv ====
// Purpose: Port-level assertions for the secondary time base block.
// Assumes: One clock; register writes are mirrored from the bus port.
// Notes:   Mirrors stand in for enables that the design keeps inside.
`timescale 1ns/1ps
`default_nettype none
module pwst_top_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic CLIMIT_MODE,
    input wire logic FAULT_EVT,
    input wire logic CLIMIT_EVT,
    input wire logic TRIGGER_EVT,
    input wire logic GEN_IRQ,
    input wire logic CHOP_CLK,
    input wire logic TB_RESET,
    input wire logic [1:0] DT_MODE,
    input wire logic SHORTEN_HIGH,
    input wire logic SHORTEN_LOW
);
    // ==========================================================
    // Helper mirrors
    logic [15:0] gc_r;
    logic chop_en_r;
    logic [3:0] chop_off_r;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            gc_r <= 16'h0000;
        end else if (WR && ADDR == pwst_pkg::ADDR_GEN_CTRL) begin
            gc_r <= WDATA;
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            chop_en_r <= 1'h0;
        end else if (WR && ADDR == pwst_pkg::ADDR_CHOP) begin
            chop_en_r <= WDATA[15];
        end
    end
    // A stopped generator may still flush one pulse, so allow a margin.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            chop_off_r <= 4'h0;
        end else if (chop_en_r) begin
            chop_off_r <= 4'h0;
        end else if (chop_off_r != 4'hf) begin
            chop_off_r <= chop_off_r + 4'h1;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_fault_taken;
        FAULT_EVT && gc_r[12];
    endsequence
    sequence s_climit_taken;
        CLIMIT_EVT && gc_r[11];
    endsequence
    sequence s_trig_taken;
        TRIGGER_EVT && gc_r[10];
    endsequence
    chk_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
        else $error("read data not zero outside a read answer");
    chk_unmapped_read: assert property (RD && ADDR > pwst_pkg::ADDR_GEN_CTRL
        |=> RDATA == 16'h0000) else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (RD && ADDR == pwst_pkg::ADDR_GEN_CTRL
        |=> RDATA[12:0] == (gc_r[12:0] & 13'h1fef))
        else $error("control readback differs from last write");
    chk_fault_irq: assert property (s_fault_taken |=> ##1 GEN_IRQ)
        else $error("fault event did not raise the request");
    chk_climit_irq: assert property (s_climit_taken |=> ##1 GEN_IRQ)
        else $error("limit event did not raise the request");
    chk_trig_irq: assert property (s_trig_taken |=> ##1 GEN_IRQ)
        else $error("trigger event did not raise the request");
    chk_irq_clear: assert property (WR && ADDR == pwst_pkg::ADDR_GEN_CTRL
        && WDATA[12:10] == 3'h0 |=> ##2 !GEN_IRQ)
        else $error("request stayed after enables cleared");
    chk_shorten_off: assert property (DT_MODE != pwst_pkg::DT_COMPENSATE
        |-> !SHORTEN_HIGH && !SHORTEN_LOW)
        else $error("shorten active outside compensation");
    chk_shorten_pair: assert property (DT_MODE == pwst_pkg::DT_COMPENSATE
        |-> SHORTEN_HIGH != SHORTEN_LOW)
        else $error("shorten outputs not complementary");
    chk_tbreset_fire: assert property (CLIMIT_EVT && !CLIMIT_MODE && gc_r[9]
        && gc_r[1] |=> TB_RESET)
        else $error("limit event did not reset the time base");
    chk_tbreset_cause: assert property (TB_RESET |-> $past(CLIMIT_EVT))
        else $error("time base reset without a limit event");
    chk_chop_stopped: assert property (chop_off_r > 4'h3 |-> !CHOP_CLK)
        else $error("chop pulse while generator disabled");
endmodule // pwst_top_chk

bind pwst_top pwst_top_chk u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CLIMIT_MODE(CLIMIT_MODE), .FAULT_EVT(FAULT_EVT),
    .CLIMIT_EVT(CLIMIT_EVT), .TRIGGER_EVT(TRIGGER_EVT), .GEN_IRQ(GEN_IRQ),
    .CHOP_CLK(CHOP_CLK), .TB_RESET(TB_RESET), .DT_MODE(DT_MODE),
    .SHORTEN_HIGH(SHORTEN_HIGH), .SHORTEN_LOW(SHORTEN_LOW)
);
`default_nettype wire

// ==== verification/pwst_tb.sv ====
// Purpose: Self-checking bench for the secondary time base block.
// Assumes: Register offsets and reset values from the package.
// Notes:   Read answers pass through a queue; pulse gaps are timed.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, rst, wr, rd, mod_en, cl_mode, flt, clv, trg, pend, cin;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, pri_per, g_duty, g_phase, sd, old, v;
    logic [13:0] dt_v, alt_v;
    logic se_trig, sec_match, se_irq, gen_irq, chop_clk, tb_rst;
    logic sh_hi, sh_lo, c_align, use_sec, lo_e, hi_e, rd_q;
    logic [1:0] dt_mode;
    pwst_pkg::pwst_active_type active;
    logic [15:0] exp_q[$];
    logic [31:0] seed, tmp;
    int errors, cmp_count, cyc, nm, ps_exp, chop_prev, chop_gap;
    int n_chop, n_trig, n_tbr;

    pwst_top u_dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .MODULE_ENABLE(mod_en),
        .CLIMIT_MODE(cl_mode), .FAULT_EVT(flt), .CLIMIT_EVT(clv),
        .TRIGGER_EVT(trg), .PRI_PERIOD_END(pend), .PRIMARY_PERIOD(pri_per),
        .GEN_DUTY(g_duty), .GEN_PHASE(g_phase), .DT_VALUE(dt_v),
        .ALT_DT_VALUE(alt_v), .COMP_INPUT(cin), .SPECIAL_EVENT_TRIG(se_trig),
        .SEC_MATCH(sec_match), .SE_IRQ(se_irq), .GEN_IRQ(gen_irq),
        .CHOP_CLK(chop_clk), .TB_RESET(tb_rst), .ACTIVE(active),
        .DT_MODE(dt_mode), .SHORTEN_HIGH(sh_hi), .SHORTEN_LOW(sh_lo),
        .CENTER_ALIGN(c_align), .USE_SEC_TB(use_sec));

    // ==========================================================
    // Tasks
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] e);
        cmp_count++;
        if (got !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, e);
        end
    endtask
    function automatic logic [15:0] msk(input int a);
        case (a)
            0: return 16'h0c0f;
            1: return 16'h0007;
            2, 3, 5: return 16'hffff;
            4: return 16'h83ff;
            6: return 16'h1fef;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge sys_clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'h1;
        exp_q.push_back(e);
        @(posedge sys_clk);
        rd <= 1'h0;
    endtask
    task automatic evt(input logic [3:0] m);
        @(posedge sys_clk);
        {flt, clv, trg, pend} <= m;
        @(posedge sys_clk);
        {flt, clv, trg, pend} <= 4'h0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Monitor
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (rd_q) begin
            chk16(rdata, exp_q.pop_front());
        end
        rd_q <= rd;
        if (sec_match) nm = nm + 1;
        if (se_trig) begin
            chk16(16'(nm), 16'(ps_exp + 1));
            n_trig++;
            nm = 0;
        end
        if (chop_clk) begin
            if (chop_prev != 0) chk16(16'(cyc - chop_prev), 16'(chop_gap));
            chop_prev = cyc;
            n_chop++;
        end
        if (tb_rst) n_tbr++;
    end

    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // The full sequence needs about 3000 cycles.
    initial begin
        #2000000;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst, wr, rd, mod_en, cl_mode, flt, clv, trg, pend, rd_q} = 10'h200;
        {errors, cmp_count, cyc, nm, ps_exp, chop_prev, n_chop} = '0;
        {chop_gap, n_trig, n_tbr} = '0;
        seed = 32'h16;
        addr = 4'h0;
        wdata = 16'h0000;
        tmp = rnd();
        {pri_per, g_duty} = tmp;
        tmp = rnd();
        {g_phase, sd} = tmp;
        tmp = rnd();
        {dt_v, alt_v, cin} = tmp[28:0];
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        for (int a = 0; a < 8; a++) rd_reg(4'(a), (a == 2) ?
            pwst_pkg::PERIOD_RST : pwst_pkg::ZERO_RST);
        for (int a = 0; a < 16; a++) begin
            // Chop stays off here: its pulses are timed later on.
            wr_reg(4'(a), 16'(rnd()) & ((a == 4) ? 16'h7fff : 16'hffff));
            rd_reg(4'(a), wdata & msk(a));
        end
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'hffff);
        rd_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h1fef);
        for (int k = 0; k < 3; k++) begin
            v = 16'h1000 >> k;
            wr_reg(pwst_pkg::ADDR_GEN_CTRL, v);
            evt(4'h8 >> k);
            rd_reg(pwst_pkg::ADDR_GEN_CTRL, v | (16'h8000 >> k));
            chk16(16'(gen_irq), 16'h0001);
            wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0000);
            evt(4'h8 >> k);
            rd_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0000);
            chk16(16'(gen_irq), 16'h0000);
        end
        wr_reg(pwst_pkg::ADDR_SHARED_DUTY, sd);
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0301);
        idle(3);
        chk16(active.duty, sd);
        chk16(active.period, g_phase);
        chk16(16'(active.deadtime), 16'(dt_v));
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0001);
        idle(3);
        chk16(active.duty, g_duty);
        chk16(active.period, pri_per);
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0000);
        old = g_duty;
        g_duty <= 16'(rnd());
        idle(3);
        chk16(active.duty, old);
        evt(4'h1);
        idle(2);
        chk16(active.duty, g_duty);
        chk16(16'(active.alt_deadtime), 16'(alt_v));
        for (int i = 0; i < 8; i++) begin
            tmp = rnd();
            cin <= tmp[0];
            v = {6'h0, i[1], 1'h0, i[1:0], i[2], 1'h0, i[0], 1'h1, 2'h0};
            wr_reg(pwst_pkg::ADDR_GEN_CTRL, v);
            idle(2);
            lo_e = (i[1:0] == 2'h3) && (i[2] ^ cin);
            hi_e = (i[1:0] == 2'h3) && !(i[2] ^ cin);
            chk16(16'(dt_mode), 16'(i[1:0]));
            chk16({sh_lo, sh_hi}, {lo_e, hi_e});
            chk16(16'(use_sec), 16'(i[0]));
            chk16(16'(c_align), 16'(i[1]));
        end
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0202);
        evt(4'h4);
        cl_mode <= 1'h1;
        evt(4'h4);
        cl_mode <= 1'h0;
        wr_reg(pwst_pkg::ADDR_GEN_CTRL, 16'h0002);
        evt(4'h4);
        idle(2);
        chk16(16'(n_tbr), 16'h0001);
        for (int d = 0; d < 7; d++) begin
            wr_reg(pwst_pkg::ADDR_CHOP, 16'h0000);
            wr_reg(pwst_pkg::ADDR_CLKDIV, 16'(d));
            idle(2);
            {chop_prev, n_chop} = '0;
            chop_gap = 3 << d;
            wr_reg(pwst_pkg::ADDR_CHOP, 16'h8002);
            idle(4 * chop_gap);
            chk16(16'(n_chop > 2), 16'h0001);
        end
        wr_reg(pwst_pkg::ADDR_CHOP, 16'h0000);
        idle(2);
        n_chop = 0;
        idle(40);
        chk16(16'(n_chop), 16'h0000);
        wr_reg(pwst_pkg::ADDR_CLKDIV, 16'h0000);
        wr_reg(pwst_pkg::ADDR_PERIOD, 16'h0003);
        wr_reg(pwst_pkg::ADDR_COMPARE, 16'h0001);
        for (int ps = 0; ps < 16; ps++) begin
            mod_en <= 1'h0;
            wr_reg(pwst_pkg::ADDR_SEC_CTRL, 16'h0800 | 16'(ps));
            {nm, n_trig} = '0;
            ps_exp = ps;
            mod_en <= 1'h1;
            idle(8 * (ps + 1) + 4);
            chk16(16'(n_trig > 1), 16'h0001);
        end
        rd_reg(pwst_pkg::ADDR_SEC_CTRL, 16'h180f);
        chk16(16'(se_irq), 16'h0001);
        mod_en <= 1'h0;
        wr_reg(pwst_pkg::ADDR_SEC_CTRL, 16'h0000);
        idle(2);
        rd_reg(pwst_pkg::ADDR_SEC_CTRL, 16'h0000);
        idle(1);
        rst <= 1'h1;
        idle(2);
        rst <= 1'h0;
        rd_reg(pwst_pkg::ADDR_PERIOD, pwst_pkg::PERIOD_RST);
        idle(3);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
